// *** logic/jsm_pkg.sv ***
// Constants and types for the sync and marker input selector
`default_nettype none
package jsm_pkg;
	localparam int JSM_AW = 4;
	localparam int JSM_DW = 32;
	localparam int JSM_CNT_W = 16;

	localparam logic [JSM_AW-1:0] JSM_OFS_CTRL = 4'h0;
	localparam logic [JSM_AW-1:0] JSM_OFS_STATUS = 4'h4;
	localparam logic [JSM_AW-1:0] JSM_OFS_MARK = 4'h8;
	localparam logic [JSM_AW-1:0] JSM_OFS_SYSREF = 4'hC;

	localparam int JSM_CTRL_W = 6;
	localparam logic [JSM_CTRL_W-1:0] JSM_CTRL_RST = 6'h00;

	localparam logic [1:0] JSM_RESP_OKAY = 2'h0;
	localparam logic [1:0] JSM_RESP_SLVERR = 2'h2;

	// Control word; bit 0 is sync_select
	typedef struct packed {
		logic marker_dc_coupling_enable;
		logic sysref_dc_coupling_enable;
		logic link_64b66b;
		logic marker_receiver_enable;
		logic marker_enable;
		logic sync_select;
	} jsm_ctrl_s;

	typedef struct packed {
		logic sync_at_mark;
		logic [JSM_CNT_W-1:0] sample;
	} jsm_mark_s;

	typedef enum logic [3:0] {
		JSM_IDLE = 4'h1,
		JSM_CGS = 4'h2,
		JSM_ILAS = 4'h4,
		JSM_DATA = 4'h8
	} jsm_link_e;
endpackage
`default_nettype wire

// *** logic/jsm_sync_marker.sv ***
// Sync source select, link start sequencing, marker and timing reference
`default_nettype none
module jsm_sync_marker
	import jsm_pkg::*;
#(
	parameter int CNT_W = JSM_CNT_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [JSM_AW-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [JSM_DW-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [JSM_AW-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [JSM_DW-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic single_ended_sync_in,
	input wire logic marker_diff_in,
	input wire logic sysref_diff_in,
	output logic sync_asserted,
	output logic cgs_active,
	output logic ilas_start,
	output logic nco_sync_trigger,
	output logic marker_tag,
	output logic marker_sync_tag,
	output logic sysref_event,
	output logic sysref_dc_coupling_enable,
	output logic marker_dc_coupling_enable
);
	// Three-stage synchronisers with agreement filter
	logic [2:0] se_sh_r, mk_sh_r, sr_sh_r;
	logic se_f_r, mk_f_r, sr_f_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			se_sh_r <= 3'h7;
			mk_sh_r <= 3'h7;
			sr_sh_r <= 3'h0;
			se_f_r <= 1'b1;
			mk_f_r <= 1'b1;
			sr_f_r <= 1'b0;
		end else begin
			se_sh_r <= {se_sh_r[1:0], single_ended_sync_in};
			mk_sh_r <= {mk_sh_r[1:0], marker_diff_in};
			sr_sh_r <= {sr_sh_r[1:0], sysref_diff_in};
			if (se_sh_r[1] == se_sh_r[2]) se_f_r <= se_sh_r[2];
			if (mk_sh_r[1] == mk_sh_r[2]) mk_f_r <= mk_sh_r[2];
			if (sr_sh_r[1] == sr_sh_r[2]) sr_f_r <= sr_sh_r[2];
		end
	end

	jsm_ctrl_s ctrl_r;

	// Disabled receiver reads as idle high, so it neither marks nor syncs
	wire marker_lvl = ctrl_r.marker_receiver_enable ? mk_f_r : 1'b1;
	// Both sources are active low; select is not guarded, so a switch onto a low source reads as a fall
	wire sync_lvl = ctrl_r.sync_select ? marker_lvl
		: se_f_r;
	wire sync_req = ~sync_lvl;

	logic sync_req_d_r, marker_d_r, sysref_d_r;
	wire sync_fall = sync_req & ~sync_req_d_r;
	wire sync_rise = ~sync_req & sync_req_d_r;
	wire marker_rise = marker_lvl & ~marker_d_r;
	wire sysref_rise = sr_f_r & ~sysref_d_r;

	jsm_link_e state_r, state_nxt;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			JSM_IDLE: begin
				if (!ctrl_r.link_64b66b && sync_req) state_nxt = JSM_CGS;
			end
			JSM_CGS: begin
				if (ctrl_r.link_64b66b) state_nxt = JSM_IDLE;
				else if (sync_rise) state_nxt = JSM_ILAS;
			end
			JSM_ILAS: begin
				state_nxt = JSM_DATA;
			end
			JSM_DATA: begin
				if (ctrl_r.link_64b66b) state_nxt = JSM_IDLE;
				else if (sync_req) state_nxt = JSM_CGS;
			end
			default: state_nxt = JSM_IDLE;
		endcase
	end

	logic [CNT_W-1:0] sample_cnt_r, sysref_cnt_r;
	logic [CNT_W-1:0] mark_sample_r;
	logic mark_sync_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= JSM_IDLE;
			sync_req_d_r <= 1'b0;
			marker_d_r <= 1'b1;
			sysref_d_r <= 1'b0;
			sync_asserted <= 1'b0;
			cgs_active <= 1'b0;
			ilas_start <= 1'b0;
			nco_sync_trigger <= 1'b0;
			marker_tag <= 1'b0;
			marker_sync_tag <= 1'b0;
			sysref_event <= 1'b0;
			sample_cnt_r <= '0;
			sysref_cnt_r <= '0;
			mark_sample_r <= '0;
			mark_sync_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			sync_req_d_r <= sync_req;
			marker_d_r <= marker_lvl;
			sysref_d_r <= sr_f_r;
			sync_asserted <= sync_req;
			cgs_active <= (state_nxt == JSM_CGS);
			ilas_start <= (state_nxt == JSM_ILAS);
			nco_sync_trigger <= ctrl_r.link_64b66b & sync_fall;
			sample_cnt_r <= sample_cnt_r + 1'b1;
			marker_tag <= ctrl_r.marker_enable & marker_rise;
			marker_sync_tag <= ctrl_r.marker_enable & marker_rise
				& sync_req;
			if (ctrl_r.marker_enable && marker_rise) begin
				mark_sample_r <= sample_cnt_r;
				mark_sync_r <= sync_req;
			end
			sysref_event <= sysref_rise;
			if (sysref_rise) sysref_cnt_r <= sysref_cnt_r + 1'b1;
		end
	end

	// AXI4-Lite slave: address and data accepted in either order
	logic aw_got_r, w_got_r;
	logic [JSM_AW-1:0] aw_addr_r;
	logic [JSM_DW-1:0] w_data_r;
	logic [3:0] w_strb_r;
	wire aw_hs = s_axi_awvalid & s_axi_awready;
	wire w_hs = s_axi_wvalid & s_axi_wready;
	wire do_wr = aw_got_r & w_got_r & ~s_axi_bvalid;
	wire aw_got_nxt = (aw_got_r | aw_hs) & ~do_wr;
	wire w_got_nxt = (w_got_r | w_hs) & ~do_wr;
	wire bvalid_nxt = do_wr | (s_axi_bvalid & ~s_axi_bready);
	wire wr_ctrl = do_wr & (aw_addr_r == JSM_OFS_CTRL);
	wire wr_ok = (aw_addr_r == JSM_OFS_CTRL) | (aw_addr_r == JSM_OFS_STATUS)
		| (aw_addr_r == JSM_OFS_MARK) | (aw_addr_r == JSM_OFS_SYSREF);

	wire ar_hs = s_axi_arvalid & s_axi_arready;
	wire rvalid_nxt = ar_hs | (s_axi_rvalid & ~s_axi_rready);
	jsm_mark_s mark_w;
	assign mark_w = '{sync_at_mark: mark_sync_r, sample: mark_sample_r};
	wire [JSM_DW-1:0] status_w = {{(JSM_DW-7){1'b0}}, sr_f_r,
		marker_lvl, se_f_r, state_r};
	wire [JSM_DW-1:0] rd_ctrl = {{(JSM_DW-JSM_CTRL_W){1'b0}}, ctrl_r};
	wire [JSM_DW-1:0] rd_mark = {{(JSM_DW-CNT_W-1){1'b0}}, mark_w};
	wire [JSM_DW-1:0] rd_sysref = {{(JSM_DW-CNT_W){1'b0}}, sysref_cnt_r};
	wire sel_ctrl = (s_axi_araddr == JSM_OFS_CTRL);
	wire sel_status = (s_axi_araddr == JSM_OFS_STATUS);
	wire sel_mark = (s_axi_araddr == JSM_OFS_MARK);
	wire sel_sysref = (s_axi_araddr == JSM_OFS_SYSREF);
	wire rd_hit = sel_ctrl | sel_status | sel_mark | sel_sysref;
	wire [JSM_DW-1:0] rd_mux = sel_ctrl ? rd_ctrl : sel_status ? status_w
		: sel_mark ? rd_mark : sel_sysref ? rd_sysref : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= JSM_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= JSM_RESP_OKAY;
			s_axi_rdata <= '0;
			ctrl_r <= JSM_CTRL_RST;
		end else begin
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			if (aw_hs) aw_addr_r <= s_axi_awaddr;
			if (w_hs) w_data_r <= s_axi_wdata;
			if (w_hs) w_strb_r <= s_axi_wstrb;
			s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
			s_axi_wready <= ~w_got_nxt & ~bvalid_nxt;
			s_axi_bvalid <= bvalid_nxt;
			if (do_wr) s_axi_bresp <= wr_ok ? JSM_RESP_OKAY : JSM_RESP_SLVERR;
			if (wr_ctrl && w_strb_r[0]) ctrl_r <= w_data_r[JSM_CTRL_W-1:0];
			s_axi_arready <= ~rvalid_nxt;
			s_axi_rvalid <= rvalid_nxt;
			if (ar_hs) begin
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? JSM_RESP_OKAY : JSM_RESP_SLVERR;
			end
		end
	end

	assign sysref_dc_coupling_enable = ctrl_r.sysref_dc_coupling_enable;
	assign marker_dc_coupling_enable = ctrl_r.marker_dc_coupling_enable;
endmodule
`default_nettype wire

// *** verif/jsm_sync_marker_checker.sv ***
// Timing checks on the sync and marker selector outputs
`default_nettype none
module jsm_sync_marker_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic single_ended_sync_in,
	input wire logic marker_diff_in,
	input wire logic sysref_diff_in,
	input wire logic sync_asserted,
	input wire logic cgs_active,
	input wire logic ilas_start,
	input wire logic nco_sync_trigger,
	input wire logic marker_tag,
	input wire logic marker_sync_tag,
	input wire logic sysref_event
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_pulse(x);
		x ##1 !x;
	endsequence
	// Outputs show a pin change five sampled edges after it was first seen
	sequence s_rise(x);
		$past(x, 5) && !$past(x, 6);
	endsequence
	a_cgs_sync: assert property (cgs_active |-> sync_asserted)
		else $error("cgs without sync");
	a_sync_src: assert property (sync_asserted |->
		!$past(single_ended_sync_in, 5) || !$past(marker_diff_in, 5))
		else $error("sync without low source");
	a_ilas_rise: assert property (ilas_start |->
		$past(cgs_active) && !cgs_active && !sync_asserted)
		else $error("ilas not from cgs");
	a_ilas_once: assert property (ilas_start |-> s_pulse(ilas_start))
		else $error("ilas pulse too long");
	a_nco_nolink: assert property (nco_sync_trigger |-> !cgs_active)
		else $error("nco trigger during cgs");
	a_mark_rise: assert property (marker_tag |->
		s_rise(marker_diff_in))
		else $error("tag without marker rise");
	a_mark_sync: assert property (marker_sync_tag |-> marker_tag)
		else $error("sync tag alone");
	a_sysref_rise: assert property (sysref_event |->
		s_rise(sysref_diff_in))
		else $error("sysref event without rise");
endmodule
`default_nettype wire

// *** verif/jsm_rx_model.sv ***
// Link receiver model that drives the active-low sync request
`default_nettype none
module jsm_rx_model (
	input wire logic aclk,
	input wire logic want_align,
	output logic sync_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Low while alignment is wanted, back high the clock after want_align drops
	always @(posedge aclk) sync_n <= !want_align;
endmodule
`default_nettype wire

// *** verif/tb_jsm_sync_marker.sv ***
// Self-checking bench for the sync and marker selector
`default_nettype none
module tb_jsm_sync_marker;
	import jsm_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0;
	logic s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
	logic [JSM_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [JSM_DW-1:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, single_ended_sync_in, marker_diff_in;
	logic sysref_diff_in = '0, sync_asserted, cgs_active, ilas_start;
	logic nco_sync_trigger, marker_tag, marker_sync_tag, sysref_event;
	logic sysref_dc_coupling_enable, marker_dc_coupling_enable;
	logic want_align = '0, sel = '0, mk = 1'h1, sync_n;
	logic [31:0] seed = 32'h913E1CDC;
	logic [33:0] exp_q[$];
	int miscompares = 0, checked = 0;
	// Differential sync leaves the pin tied to ground
	assign single_ended_sync_in = sel ? 1'h0 : sync_n;
	assign marker_diff_in = sel ? sync_n : mk;
	jsm_sync_marker DUT (.*);
	jsm_rx_model rx (.aclk(aclk), .want_align(want_align), .sync_n(sync_n));
	initial begin
		forever #20 aclk = !aclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [33:0] e, g);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wait_hi(ref logic s);
		for (int i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (s === 1'h1) return;
		end
		miscompares++;
		summarize();
	endtask
	task automatic bus(input logic w, input logic [3:0] a, logic [33:0] e);
		exp_q.push_back(w ? {e[33:32], 32'h0} : e);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= e[31:0];
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w;
		for (int i = 0; i < 100; i++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= '0;
			if (s_axi_wready) s_axi_wvalid <= '0;
			if (s_axi_arready) s_axi_arvalid <= '0;
			if ((s_axi_bvalid && s_axi_bready)
				|| (s_axi_rvalid && s_axi_rready)) begin
				s_axi_bready <= '0;
				s_axi_rready <= '0;
				@(posedge aclk);
				return;
			end
		end
		miscompares++;
		summarize();
	endtask
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready)
			chk("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0});
		if (s_axi_rvalid && s_axi_rready)
			chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (6) @(posedge aclk);
		bus(1'b0, JSM_OFS_CTRL, 34'h0);
		mk <= '0;
		repeat (8) @(posedge aclk);
		chk("cgs", 34'h0, 34'(cgs_active));
		mk <= 1'h1;
		want_align <= 1'h1;
		wait_hi(cgs_active);
		chk("sync", 34'h1, 34'(sync_asserted));
		bus(1'b0, JSM_OFS_STATUS, 34'h22);
		want_align <= '0;
		wait_hi(ilas_start);
		bus(1'b0, JSM_OFS_STATUS, 34'h38);
		bus(1'b1, JSM_OFS_CTRL, 34'h1);
		sel <= 1'h1;
		want_align <= 1'h1;
		repeat (8) @(posedge aclk);
		chk("cgs", 34'h0, 34'(cgs_active));
		bus(1'b1, JSM_OFS_CTRL, 34'h7);
		wait_hi(cgs_active);
		want_align <= '0;
		wait_hi(marker_tag);
		chk("msync", 34'h0, 34'(marker_sync_tag));
		// Pin must settle high first, or the switch itself reads as a fall
		sel <= '0;
		repeat (6) @(posedge aclk);
		bus(1'b1, JSM_OFS_CTRL, 34'h8);
		want_align <= 1'h1;
		wait_hi(nco_sync_trigger);
		repeat (6) @(posedge aclk);
		chk("cgs", 34'h0, 34'(cgs_active));
		bus(1'b1, JSM_OFS_CTRL, 34'hE);
		mk <= '0;
		repeat (6) @(posedge aclk);
		mk <= 1'h1;
		wait_hi(marker_tag);
		chk("msync", 34'h1, 34'(marker_sync_tag));
		want_align <= '0;
		seed = lfsr(seed);
		repeat (seed[2:0] | 3'h1) begin
			sysref_diff_in <= 1'h1;
			wait_hi(sysref_event);
			sysref_diff_in <= '0;
			repeat (6) @(posedge aclk);
		end
		bus(1'b0, JSM_OFS_SYSREF, 34'(seed[2:0] | 3'h1));
		seed = lfsr(seed);
		bus(1'b1, JSM_OFS_CTRL, 34'(seed));
		repeat (2) @(posedge aclk);
		chk("dc", 34'(seed[5:4]), 34'({marker_dc_coupling_enable,
			sysref_dc_coupling_enable}));
		bus(1'b0, JSM_OFS_CTRL, 34'(seed[5:0]));
		// Unmapped word answers with an error response
		bus(1'b1, 4'h2, 34'h2_0000_0000);
		bus(1'b0, 4'h2, 34'h2_0000_0000);
		aresetn <= '0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		chk("dc", 34'h0, 34'({marker_dc_coupling_enable,
			sysref_dc_coupling_enable}));
		bus(1'b0, JSM_OFS_CTRL, 34'h0);
		summarize();
	end
endmodule
bind jsm_sync_marker jsm_sync_marker_checker chk (.*);
`default_nettype wire
